//--- rtl/calu_datapath.sv
// Arithmetic and logic datapath with Wishbone register access
// Overview of operation
// RULE1: 16-bit counter advances by one per instruction
// RULE2: taken skip advances counter by two
// RULE3: jump or call loads counter with operand
// RULE4: counter loads from result bus, drives source
// RULE5: four hidden 16-bit scratch registers
// RULE6: extend bit links accumulators in rotates
// RULE7: add or increment carry goes to extend
// RULE8: extend clear, complement, test, panel, display
// RULE9: add or increment overflow sets overflow flag
// RULE10: overflow clear, set, test, panel, display
// RULE11: group select plus four-bit function number
// RULE12: shifter puts result on result bus
// RULE13: reference to accumulator sets addressed flag
// RULE14: flagged accesses go to accumulator
// RULE15: address zero first, one second accumulator
// RULE16: flags update with accumulator write
`timescale 1ns/1ps
module calu_datapath import calu_pkg::*; #(
	parameter int W = CALU_DW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic uop_valid_i,
	input wire calu_ssrc_t s_src_i,
	input wire calu_rsrc_t r_src_i,
	input wire logic arith_i,
	input wire logic [3:0] fn_i,
	input wire calu_shop_t shift_i,
	input wire calu_dst_t store_i,
	input wire logic store_mem_i,
	input wire calu_flop_t flag_op_i,
	input wire calu_pcop_t pc_op_i,
	input wire logic skip_met_i,
	input wire logic mem_ref_i,
	input wire logic [14:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic [W-1:0] mem_data_i,
	input wire logic panel_cmp_ext_i,
	input wire logic panel_cmp_ovf_i,
	output logic [W-1:0] pc_o,
	output logic [W-1:0] result_o,
	output logic ext_o,
	output logic ovf_o,
	output logic accum_first_addressed_flag_o,
	output logic accum_second_addressed_flag_o,
	output logic mem_inhibit_o
);
	calu_state_t q;
	calu_state_t nxt_q;
	logic [W-1:0] r_bus;
	logic [W-1:0] s_bus;
	logic [W-1:0] f_out;
	logic [W-1:0] t_bus;
	logic fg_carry;
	logic fg_ovf;
	logic sh_ext;
	logic wb_req;
	logic wb_wr;
	logic wb_rd;
	logic [31:0] rd_mux;
	logic add_like;
	logic acc_dst_a;
	logic acc_dst_b;
	logic [CALU_IRQ_W-1:0] ev;

	// Operand bus source
	always_comb begin
		unique case (r_src_i)
			CALU_R_A: r_bus = q.acc_a;
			CALU_R_B: r_bus = q.acc_b;
			default: r_bus = '0;
		endcase
	end

	// Source bus: counter, scratch, memory data, extend bit or redirected accumulator
	always_comb begin
		unique case (s_src_i)
			CALU_S_PC: s_bus = q.pc; // see RULE4
			CALU_S_SP1: s_bus = q.sp[0]; // see RULE5
			CALU_S_SP2: s_bus = q.sp[1];
			CALU_S_SP3: s_bus = q.sp[2];
			CALU_S_SP4: s_bus = q.sp[3];
			CALU_S_MEM: begin
				if (q.aaf) begin
					s_bus = q.acc_a; // see RULE14
				end else if (q.abf) begin
					s_bus = q.acc_b; // see RULE14
				end else begin
					s_bus = mem_data_i;
				end
			end
			CALU_S_EXT: s_bus = {{(W-1){1'b0}}, q.ext}; // see RULE8
			default: s_bus = '0;
		endcase
	end

	// Function generator picks group and function number
	calu_fgen #(.W(W)) u_fgen ( // see RULE11
		.r_i(r_bus),
		.s_i(s_bus),
		.arith_i(arith_i),
		.fn_i(fn_i),
		.f_o(f_out),
		.carry_o(fg_carry),
		.ovf_o(fg_ovf)
	);

	// Shifter drives the result bus
	calu_shift #(.W(W)) u_shift ( // see RULE12
		.d_i(f_out),
		.ext_i(q.ext),
		.op_i(shift_i),
		.q_o(t_bus),
		.ext_o(sh_ext)
	);

	// Bus request decode
	assign wb_req = wb_cyc_i & wb_stb_i & ~q.ack;
	assign wb_wr = wb_req & wb_we_i;
	assign wb_rd = wb_req & ~wb_we_i;

	// Read data selection; unmapped addresses read zero
	always_comb begin
		rd_mux = '0;
		unique case (wb_adr_i)
			CALU_ADR_PC: rd_mux[W-1:0] = q.pc;
			CALU_ADR_ACC_A: rd_mux[W-1:0] = q.acc_a;
			CALU_ADR_ACC_B: rd_mux[W-1:0] = q.acc_b;
			CALU_ADR_FLAGS: begin
				rd_mux[CALU_FLG_EXT] = q.ext; // see RULE8
				rd_mux[CALU_FLG_OVF] = q.ovf; // see RULE10
				rd_mux[CALU_FLG_AAF] = q.aaf;
				rd_mux[CALU_FLG_ABF] = q.abf;
			end
			CALU_ADR_ISTAT: rd_mux[CALU_IRQ_W-1:0] = q.istat;
			CALU_ADR_IMASK: rd_mux[CALU_IRQ_W-1:0] = q.imask;
			default: rd_mux = '0;
		endcase
	end

	// Accumulator writes, from the store field or a redirected memory write
	assign acc_dst_a = uop_valid_i & ((store_i == CALU_D_A)
		| (store_mem_i & mem_wr_i & q.aaf));
	assign acc_dst_b = uop_valid_i & ((store_i == CALU_D_B)
		| (store_mem_i & mem_wr_i & q.abf & ~q.aaf));
	assign add_like = arith_i & ((fn_i == CALU_FN_ADD) | (fn_i == CALU_FN_INC));

	// Events for interrupt status
	assign ev[CALU_IRQ_CARRY] = (acc_dst_a | acc_dst_b) & add_like & fg_carry;
	assign ev[CALU_IRQ_OVF] = (acc_dst_a | acc_dst_b) & add_like & fg_ovf;
	assign ev[CALU_IRQ_REDIR] = uop_valid_i & (mem_rd_i | mem_wr_i)
		& (q.aaf | q.abf);

	// Next state
	always_comb begin
		nxt_q = q;
		nxt_q.ack = wb_req;
		nxt_q.rdat = wb_rd ? rd_mux : '0;
		if (uop_valid_i) begin
			nxt_q.result = t_bus;
			// Counter advance; a store to the counter overrides it
			unique case (pc_op_i)
				CALU_P_INC: nxt_q.pc = q.pc + CALU_PC_ONE; // see RULE1
				CALU_P_SKIP: nxt_q.pc = q.pc
					+ (skip_met_i ? CALU_PC_TWO : CALU_PC_ONE); // see RULE2
				default: nxt_q.pc = q.pc;
			endcase
			// Register stores from the result bus
			unique case (store_i)
				CALU_D_PC: nxt_q.pc = t_bus; // see RULE3 RULE4
				CALU_D_SP1: nxt_q.sp[0] = t_bus; // see RULE5
				CALU_D_SP2: nxt_q.sp[1] = t_bus;
				CALU_D_SP3: nxt_q.sp[2] = t_bus;
				CALU_D_SP4: nxt_q.sp[3] = t_bus;
				default: ;
			endcase
			if (acc_dst_a) begin
				nxt_q.acc_a = t_bus; // see RULE14
			end
			if (acc_dst_b) begin
				nxt_q.acc_b = t_bus; // see RULE14
			end
			// Extend takes the bit rotated out of the chain
			if (shift_i == CALU_SH_ERL || shift_i == CALU_SH_ERR) begin
				nxt_q.ext = sh_ext; // see RULE6
			end
			// Program flag operations
			unique case (flag_op_i)
				CALU_F_CLR_E: nxt_q.ext = 1'b0; // see RULE8
				CALU_F_CMP_E: nxt_q.ext = ~q.ext; // see RULE8
				CALU_F_CLR_O: nxt_q.ovf = 1'b0; // see RULE10
				CALU_F_SET_O: nxt_q.ovf = 1'b1; // see RULE10
				default: ;
			endcase
			// Carry and overflow land with the accumulator write
			if (ev[CALU_IRQ_CARRY]) begin
				nxt_q.ext = 1'b1; // see RULE7 RULE16
			end
			if (ev[CALU_IRQ_OVF]) begin
				nxt_q.ovf = 1'b1; // see RULE9 RULE16
			end
			// Memory reference decides which accumulator is addressed
			if (mem_ref_i) begin
				nxt_q.aaf = (mem_addr_i == CALU_MADR_ACC_A); // see RULE13 RULE15
				nxt_q.abf = (mem_addr_i == CALU_MADR_ACC_B); // see RULE13 RULE15
			end
		end
		// Panel complement from pin or control register
		if (panel_cmp_ext_i ^ (wb_wr & (wb_adr_i == CALU_ADR_CTRL)
			& wb_sel_i[0] & wb_dat_i[CALU_CTL_CMP_EXT])) begin
			nxt_q.ext = ~nxt_q.ext; // see RULE8
		end
		if (panel_cmp_ovf_i ^ (wb_wr & (wb_adr_i == CALU_ADR_CTRL)
			& wb_sel_i[0] & wb_dat_i[CALU_CTL_CMP_OVF])) begin
			nxt_q.ovf = ~nxt_q.ovf; // see RULE10
		end
		if (wb_wr & (wb_adr_i == CALU_ADR_CTRL) & wb_sel_i[0]
			& wb_dat_i[CALU_CTL_CLR_ADR]) begin
			nxt_q.aaf = 1'b0;
			nxt_q.abf = 1'b0;
		end
		// Mask register write
		if (wb_wr & (wb_adr_i == CALU_ADR_IMASK) & wb_sel_i[0]) begin
			nxt_q.imask = wb_dat_i[CALU_IRQ_W-1:0];
		end
		// Status clears on read; a new event wins over the clear
		if (wb_rd & (wb_adr_i == CALU_ADR_ISTAT)) begin
			nxt_q.istat = ev;
		end else begin
			nxt_q.istat = q.istat | ev;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= CALU_ST_RST;
		end else begin
			q <= nxt_q;
		end
	end

	// Outputs
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign irq_o = |(q.istat & q.imask);
	assign pc_o = q.pc;
	assign result_o = q.result;
	assign ext_o = q.ext; // see RULE8
	assign ovf_o = q.ovf; // see RULE10
	assign accum_first_addressed_flag_o = q.aaf;
	assign accum_second_addressed_flag_o = q.abf;
	assign mem_inhibit_o = (mem_rd_i | mem_wr_i) & (q.aaf | q.abf); // see RULE14
endmodule

//--- pkg/calu_pkg.sv
// Shared constants and types for the processor arithmetic/logic datapath
package calu_pkg;
	localparam int CALU_DW = 16;
	// Wishbone register byte addresses
	localparam logic [7:0] CALU_ADR_PC = 8'h00;
	localparam logic [7:0] CALU_ADR_SP1 = 8'h04;
	localparam logic [7:0] CALU_ADR_SP4 = 8'h10;
	localparam logic [7:0] CALU_ADR_ACC_A = 8'h14;
	localparam logic [7:0] CALU_ADR_ACC_B = 8'h18;
	localparam logic [7:0] CALU_ADR_FLAGS = 8'h1C;
	localparam logic [7:0] CALU_ADR_CTRL = 8'h20;
	localparam logic [7:0] CALU_ADR_ISTAT = 8'h24;
	localparam logic [7:0] CALU_ADR_IMASK = 8'h28;
	// Flag register bit positions
	localparam int CALU_FLG_EXT = 0;
	localparam int CALU_FLG_OVF = 1;
	localparam int CALU_FLG_AAF = 2;
	localparam int CALU_FLG_ABF = 3;
	// Control register bits (write-one pulses)
	localparam int CALU_CTL_CMP_EXT = 0;
	localparam int CALU_CTL_CMP_OVF = 1;
	localparam int CALU_CTL_CLR_ADR = 2;
	// Interrupt status bits
	localparam int CALU_IRQ_CARRY = 0;
	localparam int CALU_IRQ_OVF = 1;
	localparam int CALU_IRQ_REDIR = 2;
	localparam int CALU_IRQ_W = 3;
	// Memory operand addresses that name the accumulators
	localparam logic [14:0] CALU_MADR_ACC_A = 15'h0000;
	localparam logic [14:0] CALU_MADR_ACC_B = 15'h0001;
	// Program counter steps
	localparam logic [15:0] CALU_PC_ONE = 16'h0001;
	localparam logic [15:0] CALU_PC_TWO = 16'h0002;
	// Arithmetic function numbers
	localparam logic [3:0] CALU_FN_PASS_R = 4'h0;
	localparam logic [3:0] CALU_FN_INC = 4'h1;
	localparam logic [3:0] CALU_FN_ADD = 4'h2;
	localparam logic [3:0] CALU_FN_ADD_C = 4'h3;
	localparam logic [3:0] CALU_FN_SUB = 4'h4;
	localparam logic [3:0] CALU_FN_DEC = 4'h5;
	localparam logic [3:0] CALU_FN_PASS_S = 4'h6;
	localparam logic [3:0] CALU_FN_INC_S = 4'h7;
	localparam logic [3:0] CALU_FN_NEG = 4'h8;
	typedef enum logic [2:0] {
		CALU_S_PC, CALU_S_SP1, CALU_S_SP2, CALU_S_SP3, CALU_S_SP4,
		CALU_S_MEM, CALU_S_EXT, CALU_S_ZERO
	} calu_ssrc_t;
	typedef enum logic [1:0] {CALU_R_A, CALU_R_B, CALU_R_ZERO} calu_rsrc_t;
	typedef enum logic [2:0] {
		CALU_D_NONE, CALU_D_PC, CALU_D_SP1, CALU_D_SP2, CALU_D_SP3,
		CALU_D_SP4, CALU_D_A, CALU_D_B
	} calu_dst_t;
	typedef enum logic [1:0] {CALU_P_HOLD, CALU_P_INC, CALU_P_SKIP} calu_pcop_t;
	typedef enum logic [2:0] {
		CALU_F_NONE, CALU_F_CLR_E, CALU_F_CMP_E, CALU_F_CLR_O, CALU_F_SET_O
	} calu_flop_t;
	typedef enum logic [2:0] {
		CALU_SH_NONE, CALU_SH_SL, CALU_SH_SR, CALU_SH_ASR, CALU_SH_RL,
		CALU_SH_RR, CALU_SH_ERL, CALU_SH_ERR
	} calu_shop_t;
	typedef struct packed {
		logic [15:0] pc;
		logic [3:0][15:0] sp;
		logic [15:0] acc_a;
		logic [15:0] acc_b;
		logic [15:0] result;
		logic ext;
		logic ovf;
		logic aaf;
		logic abf;
		logic [2:0] istat;
		logic [2:0] imask;
		logic ack;
		logic [31:0] rdat;
	} calu_state_t;
	localparam calu_state_t CALU_ST_RST = '0;
endpackage

//--- rtl/calu_fgen.sv
// Function generator: arithmetic and logic groups over two operands
`timescale 1ns/1ps
module calu_fgen import calu_pkg::*; #(
	parameter int W = CALU_DW
) (
	input wire logic [W-1:0] r_i,
	input wire logic [W-1:0] s_i,
	input wire logic arith_i,
	input wire logic [3:0] fn_i,
	output logic [W-1:0] f_o,
	output logic carry_o,
	output logic ovf_o
);
	logic [W-1:0] x;
	logic [W-1:0] y;
	logic cin;
	logic [W:0] sum;
	logic [W-1:0] lg;

	// Logic group: function number is the truth table of each bit pair
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign lg[i] = fn_i[{r_i[i], s_i[i]}];
	end

	// Arithmetic group operand selection
	always_comb begin
		x = r_i;
		y = '0;
		cin = 1'b0;
		unique case (fn_i)
			CALU_FN_INC: cin = 1'b1;
			CALU_FN_ADD: y = s_i;
			CALU_FN_ADD_C: begin
				y = s_i;
				cin = 1'b1;
			end
			CALU_FN_SUB: begin
				y = ~s_i;
				cin = 1'b1;
			end
			CALU_FN_DEC: y = '1;
			CALU_FN_PASS_S: x = s_i;
			CALU_FN_INC_S: begin
				x = s_i;
				cin = 1'b1;
			end
			CALU_FN_NEG: begin
				x = ~r_i;
				cin = 1'b1;
			end
			default: x = r_i;
		endcase
	end

	// Sum with carry and two's complement overflow
	assign sum = {1'b0, x} + {1'b0, y} + {{W{1'b0}}, cin};
	assign f_o = arith_i ? sum[W-1:0] : lg;
	assign carry_o = arith_i & sum[W];
	assign ovf_o = arith_i & (x[W-1] == y[W-1]) & (sum[W-1] != x[W-1]);
endmodule

//--- rtl/calu_shift.sv
// Shifter between the function generator and the result bus
`timescale 1ns/1ps
module calu_shift import calu_pkg::*; #(
	parameter int W = CALU_DW
) (
	input wire logic [W-1:0] d_i,
	input wire logic ext_i,
	input wire calu_shop_t op_i,
	output logic [W-1:0] q_o,
	output logic ext_o
);
	// Shift and rotate; extend rotates take the extend bit into the chain
	always_comb begin
		q_o = d_i;
		ext_o = ext_i;
		unique case (op_i)
			CALU_SH_NONE: q_o = d_i;
			CALU_SH_SL: q_o = {d_i[W-2:0], 1'b0};
			CALU_SH_SR: q_o = {1'b0, d_i[W-1:1]};
			CALU_SH_ASR: q_o = {d_i[W-1], d_i[W-1:1]};
			CALU_SH_RL: q_o = {d_i[W-2:0], d_i[W-1]};
			CALU_SH_RR: q_o = {d_i[0], d_i[W-1:1]};
			CALU_SH_ERL: begin
				q_o = {d_i[W-2:0], ext_i};
				ext_o = d_i[W-1];
			end
			CALU_SH_ERR: begin
				q_o = {ext_i, d_i[W-1:1]};
				ext_o = d_i[0];
			end
		endcase
	end
endmodule

//--- verif/calu_ctl_model.sv
// Control section model issuing one micro-op at a time
`timescale 1ns/1ps
module calu_ctl_model import calu_pkg::*; (
	input wire logic clk_i,
	output logic valid_o,
	output calu_ssrc_t ssrc_o,
	output calu_rsrc_t rsrc_o,
	output logic arith_o,
	output logic [3:0] fn_o,
	output calu_shop_t shift_o,
	output calu_dst_t store_o,
	output calu_flop_t flop_o,
	output calu_pcop_t pcop_o,
	output logic skip_o,
	output logic mref_o,
	output logic [14:0] maddr_o,
	output logic [15:0] mdata_o
);
	// Idle at time zero
	initial begin
		valid_o = 1'b0;
		mref_o = 1'b0;
	end
	// Present after an edge, executed at the next one
	task automatic issue(input calu_ssrc_t ss, input calu_rsrc_t rs,
		input logic ar, input logic [3:0] fn, input calu_shop_t sh,
		input calu_dst_t st, input calu_flop_t fo, input calu_pcop_t pc,
		input logic sk, input logic [15:0] md, input logic mr,
		input logic [14:0] ma);
		@(posedge clk_i);
		ssrc_o <= ss;
		rsrc_o <= rs;
		arith_o <= ar;
		fn_o <= fn;
		shift_o <= sh;
		store_o <= st;
		flop_o <= fo;
		pcop_o <= pc;
		skip_o <= sk;
		mdata_o <= md;
		mref_o <= mr;
		maddr_o <= ma;
		valid_o <= 1'b1;
		@(posedge clk_i);
		valid_o <= 1'b0;
	endtask
endmodule

//--- verif/calu_datapath_sva.sv
// Port assertions for the datapath
`timescale 1ns/1ps
module calu_datapath_sva import calu_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic uop_valid_i,
	input wire calu_dst_t store_i,
	input wire calu_flop_t flag_op_i,
	input wire calu_pcop_t pc_op_i,
	input wire logic skip_met_i,
	input wire logic mem_ref_i,
	input wire logic [14:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic panel_cmp_ext_i,
	input wire logic panel_cmp_ovf_i,
	input wire logic [15:0] pc_o,
	input wire logic [15:0] result_o,
	input wire logic ext_o,
	input wire logic ovf_o,
	input wire logic accum_first_addressed_flag_o,
	input wire logic accum_second_addressed_flag_o,
	input wire logic mem_inhibit_o
);
	logic wbw;
	logic step;
	// Helper terms
	assign wbw = wb_cyc_i & wb_stb_i & wb_we_i;
	assign step = uop_valid_i & (store_i != CALU_D_PC);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_pulse: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack)
		else $error("ack not a single pulse");
	chk_pc_inc: assert property (
		step && pc_op_i == CALU_P_INC |=> pc_o == $past(pc_o) + 16'h0001)
		else $error("counter did not step by one");
	chk_pc_skip: assert property (
		step && pc_op_i == CALU_P_SKIP && skip_met_i
		|=> pc_o == $past(pc_o) + 16'h0002)
		else $error("counter did not step by two");
	chk_pc_load: assert property (
		uop_valid_i && store_i == CALU_D_PC |=> pc_o == result_o)
		else $error("counter not loaded from result");
	chk_pc_hold: assert property (
		!uop_valid_i |=> $stable(pc_o) && $stable(result_o))
		else $error("state moved without micro-op");
	chk_ext_clr: assert property (
		uop_valid_i && flag_op_i == CALU_F_CLR_E && store_i == CALU_D_NONE
		&& !panel_cmp_ext_i && !wbw |=> !ext_o)
		else $error("extend not cleared");
	chk_ovf_set: assert property (
		uop_valid_i && flag_op_i == CALU_F_SET_O && !panel_cmp_ovf_i
		&& !wbw |=> ovf_o)
		else $error("overflow not set");
	chk_panel_ext: assert property (
		!uop_valid_i && panel_cmp_ext_i && !wbw |=> ext_o != $past(ext_o))
		else $error("panel did not complement extend");
	chk_addr_flag: assert property (
		uop_valid_i && mem_ref_i && !wbw |=> accum_first_addressed_flag_o
		== ($past(mem_addr_i) == CALU_MADR_ACC_A) && accum_second_addressed_flag_o
		== ($past(mem_addr_i) == CALU_MADR_ACC_B))
		else $error("addressed flag wrong");
	chk_mem_inh: assert property (
		mem_inhibit_o == ((mem_rd_i || mem_wr_i) && (accum_first_addressed_flag_o
		|| accum_second_addressed_flag_o)))
		else $error("memory inhibit wrong");
endmodule
bind calu_datapath calu_datapath_sva u_sva (.*);

//--- verif/calu_datapath_tb.sv
// Self-checking bench for the datapath
`timescale 1ns/1ps
module calu_datapath_tb import calu_pkg::*;;
	typedef struct packed {
		calu_ssrc_t ss;
		calu_rsrc_t rs;
		logic ar;
		logic [3:0] fn;
		calu_shop_t sh;
		calu_dst_t st;
		calu_pcop_t pc;
		logic sk;
		logic [15:0] res;
		logic [15:0] epc;
		logic [1:0] eo;
	} calu_row_t;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, fn_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic uop_valid_i, arith_i, skip_met_i, mem_ref_i, ext_o, ovf_o;
	logic panel_cmp_ext_i, panel_cmp_ovf_i, mem_inhibit_o;
	logic [14:0] mem_addr_i;
	logic [15:0] mem_data_i, pc_o, result_o;
	logic accum_first_addressed_flag_o, accum_second_addressed_flag_o;
	calu_ssrc_t s_src_i;
	calu_rsrc_t r_src_i;
	calu_shop_t shift_i;
	calu_dst_t store_i;
	calu_flop_t flag_op_i;
	calu_pcop_t pc_op_i;
	int error_cnt = 0;
	int checks_done = 0;
	int i;
	calu_flop_t fo_l [4] = '{CALU_F_CLR_E, CALU_F_CMP_E, CALU_F_CLR_O,
		CALU_F_SET_O};
	logic [1:0] fo_x [4] = '{2'h2, 2'h3, 2'h1, 2'h3};
	calu_row_t rows [8] = '{
		'{CALU_S_MEM, CALU_R_ZERO, 1'b1, CALU_FN_PASS_S, CALU_SH_NONE,
			CALU_D_A, CALU_P_INC, 1'b0, 16'h7FFF, 16'h0001, 2'h0},
		'{CALU_S_MEM, CALU_R_ZERO, 1'b1, CALU_FN_PASS_S, CALU_SH_NONE,
			CALU_D_B, CALU_P_SKIP, 1'b0, 16'hFFFF, 16'h0002, 2'h0},
		'{CALU_S_ZERO, CALU_R_A, 1'b1, CALU_FN_INC, CALU_SH_NONE,
			CALU_D_A, CALU_P_SKIP, 1'b1, 16'h8000, 16'h0004, 2'h2},
		'{CALU_S_ZERO, CALU_R_B, 1'b1, CALU_FN_PASS_R, CALU_SH_NONE,
			CALU_D_SP1, CALU_P_INC, 1'b0, 16'hFFFF, 16'h0005, 2'h2},
		'{CALU_S_SP1, CALU_R_B, 1'b1, CALU_FN_ADD, CALU_SH_NONE,
			CALU_D_B, CALU_P_INC, 1'b0, 16'hFFFE, 16'h0006, 2'h3},
		'{CALU_S_SP1, CALU_R_A, 1'b0, 4'h6, CALU_SH_NONE,
			CALU_D_NONE, CALU_P_INC, 1'b0, 16'h7FFF, 16'h0007, 2'h3},
		'{CALU_S_ZERO, CALU_R_B, 1'b1, CALU_FN_PASS_R, CALU_SH_SL,
			CALU_D_NONE, CALU_P_INC, 1'b0, 16'hFFFC, 16'h0008, 2'h3},
		'{CALU_S_MEM, CALU_R_ZERO, 1'b1, CALU_FN_PASS_S, CALU_SH_NONE,
			CALU_D_PC, CALU_P_INC, 1'b0, 16'h1234, 16'h1234, 2'h3}};
	calu_datapath u_dut (.*, .store_mem_i(1'b0), .mem_rd_i(mem_ref_i),
		.mem_wr_i(1'b0));
	calu_ctl_model u_ctl (.clk_i, .valid_o(uop_valid_i), .ssrc_o(s_src_i),
		.rsrc_o(r_src_i), .arith_o(arith_i), .fn_o(fn_i), .shift_o(shift_i),
		.store_o(store_i), .flop_o(flag_op_i), .pcop_o(pc_op_i),
		.skip_o(skip_met_i), .mref_o(mem_ref_i), .maddr_o(mem_addr_i),
		.mdata_o(mem_data_i));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Classic Wishbone single cycle
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Memory reference micro-op
	task automatic mref(input calu_ssrc_t ss, input logic mr,
		input logic [14:0] ma);
		u_ctl.issue(ss, CALU_R_ZERO, 1'b1, CALU_FN_PASS_S, CALU_SH_NONE,
			CALU_D_NONE, CALU_F_NONE, CALU_P_HOLD, 1'b0, 16'h5555, mr, ma);
		#1;
	endtask
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Watchdog
	initial begin
		#400000;
		error_cnt++;
		results();
	end
	// Main sequence
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		panel_cmp_ext_i = 1'b0;
		panel_cmp_ovf_i = 1'b0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 8; i++) begin
			u_ctl.issue(rows[i].ss, rows[i].rs, rows[i].ar, rows[i].fn,
				rows[i].sh, rows[i].st, CALU_F_NONE, rows[i].pc, rows[i].sk,
				rows[i].res, 1'b0, 15'h0000);
			#1;
			check(result_o, rows[i].res);
			check(pc_o, rows[i].epc);
			check({ovf_o, ext_o}, rows[i].eo);
			$display("row %0d done", i);
		end
		for (i = 0; i < 4; i++) begin
			u_ctl.issue(CALU_S_ZERO, CALU_R_ZERO, 1'b1, CALU_FN_PASS_R,
				CALU_SH_NONE, CALU_D_NONE, fo_l[i], CALU_P_HOLD, 1'b0,
				16'h0000, 1'b0, 15'h0000);
			#1;
			check({ovf_o, ext_o}, fo_x[i]);
			check(pc_o, 16'h1234);
		end
		$display("flag ops done");
		mref(CALU_S_ZERO, 1'b1, 15'h0001);
		check({accum_first_addressed_flag_o, accum_second_addressed_flag_o},
			2'h1);
		check(mem_inhibit_o, 1'b1);
		mref(CALU_S_MEM, 1'b1, 15'h0000);
		check(result_o, 16'hFFFE);
		mref(CALU_S_MEM, 1'b1, 15'h0000);
		check(result_o, 16'h8000);
		mref(CALU_S_ZERO, 1'b0, 15'h0005);
		check(mem_inhibit_o, 1'b0);
		$display("redirect done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk_i);
			panel_cmp_ext_i <= (i == 0);
			panel_cmp_ovf_i <= (i == 1);
			@(posedge clk_i);
			panel_cmp_ext_i <= 1'b0;
			panel_cmp_ovf_i <= 1'b0;
			#1;
			check({ovf_o, ext_o}, i ? 2'h0 : 2'h2);
		end
		wb(1'b0, CALU_ADR_FLAGS, 32'h0);
		check(rd, 32'h4);
		wb(1'b1, CALU_ADR_CTRL, 32'h3);
		wb(1'b0, CALU_ADR_FLAGS, 32'h0);
		check(rd, 32'h7);
		wb(1'b1, CALU_ADR_CTRL, 32'h4);
		wb(1'b0, CALU_ADR_FLAGS, 32'h0);
		check(rd, 32'h3);
		wb(1'b0, CALU_ADR_SP1, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		check(irq_o, 1'b0);
		wb(1'b1, CALU_ADR_IMASK, 32'h7);
		#1;
		check(irq_o, 1'b1);
		wb(1'b0, CALU_ADR_ISTAT, 32'h0);
		check(rd[1:0], 2'h3);
		#1;
		check(irq_o, 1'b0);
		$display("register bus done");
		// Rotate right through extend: A holds 8000, extend holds 1
		u_ctl.issue(CALU_S_ZERO, CALU_R_A, 1'b1, CALU_FN_PASS_R, CALU_SH_ERR,
			CALU_D_A, CALU_F_NONE, CALU_P_HOLD, 1'b0, 16'h0000, 1'b0,
			15'h0000);
		#1;
		check(result_o, 16'hC000);
		check({ovf_o, ext_o}, 2'h2);
		$display("extend rotate done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check(pc_o, 16'h0000);
		check({ovf_o, ext_o}, 2'h0);
		$display("reset done");
		results();
	end
endmodule
